// [rtl/ptr_load_pkg.sv]
// shared constants for the pointer and register load execute block
package ptr_load_pkg;
	localparam int DATA_W   = 16;
	localparam int PAGE_W   = 9;
	localparam int OFS_W    = 7;
	localparam int ARP_W    = 3;
	localparam int NUM_AUX  = 8;
	localparam int PROD_W   = 32;
	localparam int SHORT_W  = 8;

	// operation codes presented by the decode stage
	localparam logic [3:0] OP_NONE       = 4'h0;
	localparam logic [3:0] OP_AUX_LOAD   = 4'h1;
	localparam logic [3:0] OP_AUX_SHORT  = 4'h2;
	localparam logic [3:0] OP_AUX_LONG   = 4'h3;
	localparam logic [3:0] OP_ARP_LOAD   = 4'h4;
	localparam logic [3:0] OP_PAGE_LOAD  = 4'h5;
	localparam logic [3:0] OP_PAGE_IMM   = 4'h6;
	localparam logic [3:0] OP_MAP_COPY   = 4'h7;
	localparam logic [3:0] OP_PROD_HIGH  = 4'h8;
	localparam logic [3:0] OP_STAT_LOAD  = 4'h9;

	// memory region codes
	localparam logic [2:0] REG_LOW      = 3'h0;
	localparam logic [2:0] REG_BLK_TWO  = 3'h1;
	localparam logic [2:0] REG_BLK_ZERO = 3'h2;
	localparam logic [2:0] REG_BLK_ONE  = 3'h3;
	localparam logic [2:0] REG_EXTERNAL = 3'h4;
	localparam logic [2:0] REG_OTHER    = 3'h5;

	localparam logic [PAGE_W-1:0] PAGE_EXT_MIN  = 9'h008;
	localparam logic [PAGE_W-1:0] PAGE_B0_LO    = 9'h004;
	localparam logic [PAGE_W-1:0] PAGE_B0_HI    = 9'h005;
	localparam logic [PAGE_W-1:0] PAGE_B1_HI    = 9'h007;
	localparam logic [PAGE_W-1:0] PAGE_ZERO     = 9'h000;
	localparam logic [OFS_W-1:0]  BLK_TWO_BASE  = 7'h60;
	localparam logic [PAGE_W-1:0] PAGE_CLEARED  = 9'h000;

	// reset values
	localparam logic [DATA_W-1:0] AUX_RST   = 16'h0000;
	localparam logic [ARP_W-1:0]  ARP_RST   = 3'h0;
	localparam logic [PAGE_W-1:0] PAGE_RST  = 9'h000;
	localparam logic [PROD_W-1:0] PROD_RST  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] STAT_RST  = 16'h0000;

	// AXI-Lite register map, byte addresses
	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_STATUS   = 8'h04;
	localparam logic [7:0] A_PAGE     = 8'h08;
	localparam logic [7:0] A_ARP      = 8'h0C;
	localparam logic [7:0] A_STAT0    = 8'h10;
	localparam logic [7:0] A_PROD     = 8'h14;
	localparam logic [7:0] A_AUX_BASE = 8'h20;
	localparam int         AUX_IDX_LSB = 2;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [rtl/aux_reg_file.sv]
// eight auxiliary registers with one write port, one combinational and one registered read
`timescale 1ns/1ps
`default_nettype none
module aux_reg_file
	import ptr_load_pkg::*;
(
	input  wire logic              aclk,     // cpu clock
	input  wire logic              aresetn,  // sync reset, low active
	input  wire logic              we,       // write strobe
	input  wire logic [ARP_W-1:0]  wsel,     // write index
	input  wire logic [DATA_W-1:0] wdata,    // write data
	input  wire logic [ARP_W-1:0]  rsel_a,   // read index a
	output logic [DATA_W-1:0]      rdata_a,  // read data a
	input  wire logic [ARP_W-1:0]  rsel_b,   // read index b
	output logic [DATA_W-1:0]      rdata_b   // read data b, registered
);
	logic [DATA_W-1:0] mem_r [NUM_AUX];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_AUX; i++) mem_r[i] <= AUX_RST;
			rdata_b <= AUX_RST;
		end else begin
			if (we) mem_r[wsel] <= wdata;
			rdata_b <= mem_r[rsel_b];
		end
	end

	// read port a is combinational so the next instruction sees a fresh write
	assign rdata_a = mem_r[rsel_a];
endmodule
`default_nettype wire

// [rtl/ptr_load_exec.sv]
// execute stage for the pointer, page, product-high and status loads
// How it works
// RQ1: memory word loads chosen auxiliary register
// RQ2: short or long immediate loads auxiliary register
// RQ3: short immediate zero-extended, unsigned
// RQ4: pointer load takes three-bit constant
// RQ5: legacy build: pointer keeps one bit
// RQ6: legacy build: page keeps one bit
// RQ7: page loads nine low bits or immediate
// RQ8: direct address is page over offset
// RQ9: page eight or above goes external
// RQ10: pages four to seven hit blocks zero/one
// RQ11: top 32 words of page zero: block two
// RQ12: mapped copy reads register, writes long address
// RQ13: mapped copy clears nine upper address bits
// RQ14: product high load keeps low half
// RQ15: long immediate fills auxiliary register
// RQ16: status load copies word to status zero
// RQ17: parameter picks legacy; unsupported ops illegal
// RQ18: writes land in execute, seen next
`timescale 1ns/1ps
`default_nettype none
module ptr_load_exec
	import ptr_load_pkg::*;
#(
	parameter bit LEGACY    = 1'b0,  // one-bit pointer variant
	parameter bit MAP_COPY  = 1'b1   // build the mapped copy operation
) (
	input  wire logic              aclk,          // cpu clock, 40 MHz
	input  wire logic              aresetn,       // sync reset, low active
	// decode stage
	input  wire logic              op_valid,      // operation present this cycle
	input  wire logic [3:0]        op_code,       // decoded operation
	input  wire logic [ARP_W-1:0]  op_aux_sel,    // target auxiliary register
	input  wire logic [PAGE_W-1:0] op_short_imm,  // short immediate field
	input  wire logic [DATA_W-1:0] op_long_imm,   // second instruction word
	input  wire logic              op_indirect,   // indirect addressing
	input  wire logic [OFS_W-1:0]  op_offset,     // direct offset field
	output logic                   op_illegal,    // unsupported op flagged
	// data memory port
	output logic [DATA_W-1:0]      dm_addr,       // operand address
	output logic [2:0]             dm_region,     // decoded region of dm_addr
	input  wire logic [DATA_W-1:0] dm_rdata,      // operand word
	output logic                   dm_we,         // write strobe for copy
	output logic [DATA_W-1:0]      dm_waddr,      // copy destination
	output logic [DATA_W-1:0]      dm_wdata,      // copy data
	// AXI4-Lite observation and control
	input  wire logic [7:0]        s_awaddr,      // write address
	input  wire logic              s_awvalid,     // write address valid
	output logic                   s_awready,     // write address ready
	input  wire logic [31:0]       s_wdata,       // write data
	input  wire logic [3:0]        s_wstrb,       // byte strobes
	input  wire logic              s_wvalid,      // write data valid
	output logic                   s_wready,      // write data ready
	output logic [1:0]             s_bresp,       // write response
	output logic                   s_bvalid,      // write response valid
	input  wire logic              s_bready,      // write response ready
	input  wire logic [7:0]        s_araddr,      // read address
	input  wire logic              s_arvalid,     // read address valid
	output logic                   s_arready,     // read address ready
	output logic [31:0]            s_rdata,       // read data
	output logic [1:0]             s_rresp,       // read response
	output logic                   s_rvalid,      // read response valid
	input  wire logic              s_rready       // read response ready
);
	logic [ARP_W-1:0]  arp_r;
	logic [PAGE_W-1:0] page_r;
	logic [PROD_W-1:0] prod_r;
	logic [DATA_W-1:0] stat0_r;
	logic              halt_r;
	logic [7:0]        illegal_cnt_r;
	logic [DATA_W-1:0] aux_cur;
	logic [DATA_W-1:0] aux_rd;

	wire exec = op_valid && !halt_r;

	// legacy build lacks the long immediate aux load and mapped copy
	wire unsupported = (op_code == OP_MAP_COPY && (LEGACY || !MAP_COPY)) ||
		(LEGACY && (op_code == OP_AUX_LONG)) ||
		(op_code > OP_STAT_LOAD);                                         // RQ17
	wire legal = exec && !unsupported;
	assign op_illegal = exec && unsupported;                           // RQ17

	// operand address
	wire [DATA_W-1:0] direct_addr = {page_r, op_offset};               // RQ8
	wire [DATA_W-1:0] opnd_addr = op_indirect ? aux_cur : direct_addr;
	wire [DATA_W-1:0] map_addr = {PAGE_CLEARED, opnd_addr[OFS_W-1:0]}; // RQ13
	assign dm_addr = (op_code == OP_MAP_COPY) ? map_addr : opnd_addr;  // RQ12

	// region decode on the page field of the address, plus the offset for block two
	wire [PAGE_W-1:0] a_page = dm_addr[DATA_W-1:OFS_W];
	wire [OFS_W-1:0]  a_ofs  = dm_addr[OFS_W-1:0];
	assign dm_region =
		(a_page >= PAGE_EXT_MIN) ? REG_EXTERNAL :                      // RQ9
		(a_page >= PAGE_B0_LO && a_page <= PAGE_B0_HI) ? REG_BLK_ZERO : // RQ10
		(a_page > PAGE_B0_HI && a_page <= PAGE_B1_HI) ? REG_BLK_ONE :   // RQ10
		(a_page == PAGE_ZERO && a_ofs >= BLK_TWO_BASE) ? REG_BLK_TWO :  // RQ11
		(a_page == PAGE_ZERO) ? REG_LOW : REG_OTHER;

	// mapped copy write, long immediate address
	assign dm_we    = legal && op_code == OP_MAP_COPY;                 // RQ12
	assign dm_waddr = op_long_imm;
	assign dm_wdata = dm_rdata;

	// auxiliary register write
	wire [DATA_W-1:0] short_ext = {{(DATA_W-SHORT_W){1'b0}}, op_short_imm[SHORT_W-1:0]}; // RQ3
	wire aux_we = legal && (op_code == OP_AUX_LOAD || op_code == OP_AUX_SHORT ||
		op_code == OP_AUX_LONG);
	wire [DATA_W-1:0] aux_wdata =
		(op_code == OP_AUX_LOAD)  ? dm_rdata :                          // RQ1
		(op_code == OP_AUX_SHORT) ? short_ext :                         // RQ2
		op_long_imm;                                                    // RQ15
	wire [ARP_W-1:0] aux_wsel = LEGACY ? {{(ARP_W-1){1'b0}}, op_aux_sel[0]} : op_aux_sel;

	// page pointer next value
	wire [PAGE_W-1:0] page_src = (op_code == OP_PAGE_IMM) ? op_short_imm :
		dm_rdata[PAGE_W-1:0];                                           // RQ7
	wire [PAGE_W-1:0] page_nxt = LEGACY ? {{(PAGE_W-1){1'b0}}, page_src[0]} : page_src; // RQ6
	wire page_we = legal && (op_code == OP_PAGE_LOAD || op_code == OP_PAGE_IMM);

	wire [ARP_W-1:0] arp_nxt = LEGACY ? {{(ARP_W-1){1'b0}}, op_short_imm[0]} :
		op_short_imm[ARP_W-1:0];                                        // RQ4 RQ5

	// AXI-Lite slave
	logic aw_held_r;
	logic w_held_r;
	logic [7:0]  aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic [7:0]  ar_addr_r;
	logic        ar_pend_r;

	assign s_awready = !aw_held_r && !s_bvalid;
	assign s_wready  = !w_held_r && !s_bvalid;
	assign s_arready = !ar_pend_r && !s_rvalid;
	wire do_write = aw_held_r && w_held_r && !s_bvalid;
	wire wr_ctrl  = do_write && aw_addr_r == A_CTRL;
	wire wr_ok    = aw_addr_r == A_CTRL || aw_addr_r == A_STATUS;

	wire aux_rd_hit = ar_addr_r[7:5] == A_AUX_BASE[7:5];
	aux_reg_file i_aux_reg_file (
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (aux_we),                                                // RQ18
		.wsel    (aux_wsel),
		.wdata   (aux_wdata),
		.rsel_a  (arp_r),
		.rdata_a (aux_cur),
		.rsel_b  (s_araddr[AUX_IDX_LSB+ARP_W-1:AUX_IDX_LSB]),
		.rdata_b (aux_rd)
	);

	logic [31:0] rd_mux;
	logic        rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		rd_mux = 32'h0000_0000;
		if (aux_rd_hit) rd_mux = {16'h0000, aux_rd};
		else unique case (ar_addr_r)
			A_CTRL:   rd_mux = {31'h0000_0000, halt_r};
			A_STATUS: rd_mux = {24'h00_0000, illegal_cnt_r};
			A_PAGE:   rd_mux = {23'h00_0000, page_r};
			A_ARP:    rd_mux = {29'h0000_0000, arp_r};
			A_STAT0:  rd_mux = {16'h0000, stat0_r};
			A_PROD:   rd_mux = prod_r;
			default:  rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
			s_bvalid  <= 1'b0;
			s_bresp   <= RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_wdata;
				w_strb_r <= s_wstrb;
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				s_bvalid  <= 1'b1;
				s_bresp   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_bvalid && s_bready) s_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_pend_r <= 1'b0;
			ar_addr_r <= 8'h00;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= RESP_OKAY;
		end else begin
			if (s_arvalid && s_arready) begin
				ar_pend_r <= 1'b1;
				ar_addr_r <= s_araddr;
			end
			if (ar_pend_r) begin
				ar_pend_r <= 1'b0;
				s_rvalid  <= 1'b1;
				s_rdata   <= rd_mux;
				s_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_rvalid && s_rready) s_rvalid <= 1'b0;
		end
	end

	// halt holds off execution so software can inspect a frozen state
	wire clr_illegal = do_write && aw_addr_r == A_STATUS && w_strb_r[0];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halt_r        <= 1'b0;
			illegal_cnt_r <= 8'h00;
		end else begin
			if (wr_ctrl && w_strb_r[0]) halt_r <= w_data_r[0];
			// a clear and a new illegal op in the same cycle leave the count at one
			if (op_illegal) illegal_cnt_r <= clr_illegal ? 8'h01 :
				illegal_cnt_r + 8'h01;
			else if (clr_illegal) illegal_cnt_r <= 8'h00;
		end
	end

	// architectural registers, all written in the execute cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arp_r   <= ARP_RST;
			page_r  <= PAGE_RST;
			prod_r  <= PROD_RST;
			stat0_r <= STAT_RST;
		end else begin
			if (legal && op_code == OP_ARP_LOAD) arp_r <= arp_nxt;       // RQ4 RQ18
			if (page_we) page_r <= page_nxt;                              // RQ7 RQ18
			if (legal && op_code == OP_PROD_HIGH)
				prod_r <= {dm_rdata, prod_r[DATA_W-1:0]};                 // RQ14
			if (legal && op_code == OP_STAT_LOAD) stat0_r <= dm_rdata;   // RQ16
		end
	end
endmodule
`default_nettype wire

// [tb/dm_model.sv]
// data memory partner: address-derived read words, copy write capture
`timescale 1ns/1ps
`default_nettype none
module dm_model #(
	parameter logic [15:0] SALT = 16'h5A3C  // read pattern seed
) (
	input  wire logic        aclk,      // cpu clock
	input  wire logic [15:0] dm_addr,   // operand address
	output logic [15:0]      dm_rdata,  // operand word
	input  wire logic        dm_we,     // copy write strobe
	input  wire logic [15:0] dm_waddr,  // copy destination
	input  wire logic [15:0] dm_wdata,  // copy data
	output logic [15:0]      wr_addr,   // last written address
	output logic [15:0]      wr_data    // last written word
);
	// neighbouring words differ, so a wrong address shows in the data
	assign dm_rdata = dm_addr ^ SALT;
	always_ff @(posedge aclk) begin
		if (dm_we) begin
			wr_addr <= dm_waddr;
			wr_data <= dm_wdata;
		end
	end
endmodule
`default_nettype wire

// [tb/ptr_load_exec_sva.sv]
// port assertions for the load execute block
`timescale 1ns/1ps
`default_nettype none
module ptr_load_exec_sva
	import ptr_load_pkg::*;
(
	input wire logic              aclk,         // cpu clock
	input wire logic              aresetn,      // sync reset, low active
	input wire logic              op_valid,     // operation present
	input wire logic [3:0]        op_code,      // decoded operation
	input wire logic [DATA_W-1:0] op_long_imm,  // second instruction word
	input wire logic              op_illegal,   // unsupported op flag
	input wire logic [DATA_W-1:0] dm_addr,      // operand address
	input wire logic [2:0]        dm_region,    // decoded region
	input wire logic [DATA_W-1:0] dm_rdata,     // operand word
	input wire logic              dm_we,        // copy write strobe
	input wire logic [DATA_W-1:0] dm_waddr,     // copy destination
	input wire logic [DATA_W-1:0] dm_wdata,     // copy data
	input wire logic              s_arready,    // read address ready
	input wire logic              s_arvalid,    // read address valid
	input wire logic              s_rvalid      // read response valid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire copy_op = op_valid && op_code == OP_MAP_COPY;
	a_region_ext: assert property (dm_addr[15:7] >= 9'h008 |-> dm_region == REG_EXTERNAL)
		else $error("external page not flagged");
	a_region_dual: assert property (dm_addr[15:10] == 6'h00 && dm_addr[9] |->
		dm_region == (dm_addr[8] ? REG_BLK_ONE : REG_BLK_ZERO)) else $error("dual block wrong");
	a_region_two: assert property (dm_addr[15:5] == 11'h003 |-> dm_region == REG_BLK_TWO)
		else $error("block two not decoded");
	a_copy_write: assert property (copy_op |-> dm_we && dm_waddr == op_long_imm
		&& dm_wdata == dm_rdata) else $error("copy write wrong");
	a_copy_quiet: assert property (!copy_op |-> !dm_we)
		else $error("write without copy");
	a_copy_upper: assert property (copy_op |-> dm_addr[15:7] == 9'h000)
		else $error("copy source upper bits set");
	a_illegal_flag: assert property (op_valid && op_code > 4'h9 |-> op_illegal)
		else $error("illegal op not flagged");
	a_legal_quiet: assert property (op_valid && op_code <= 4'h9 |-> !op_illegal)
		else $error("legal op flagged");
	a_read_answer: assert property (s_arvalid && s_arready |-> ##[1:2] s_rvalid)
		else $error("read answer late");
endmodule
bind ptr_load_exec ptr_load_exec_sva i_ptr_load_exec_sva (.aclk, .aresetn, .op_valid, .op_code,
	.op_long_imm, .op_illegal, .dm_addr, .dm_region, .dm_rdata, .dm_we, .dm_waddr, .dm_wdata,
	.s_arready, .s_arvalid, .s_rvalid);
`default_nettype wire

// [tb/ptr_load_exec_tb.sv]
// self-checking bench for the load execute block
`timescale 1ns/1ps
`default_nettype none
module ptr_load_exec_tb
	import ptr_load_pkg::*;
;
	localparam logic [15:0] SALT = 16'h5A3C;
	logic aclk = 1'b0, aresetn = 1'b0, op_valid = 1'b0, op_indirect = 1'b0, op_illegal, dm_we;
	logic [3:0] op_code = 4'h0, s_wstrb = 4'h0;
	logic [2:0] op_aux_sel = 3'h0, dm_region;
	logic [8:0] op_short_imm = 9'h000;
	logic [6:0] op_offset = 7'h00;
	logic [15:0] op_long_imm = 16'h0000, dm_addr, dm_rdata, dm_waddr, dm_wdata, wr_addr, wr_data;
	logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
	logic [31:0] s_wdata = 32'h0000_0000, s_rdata, rd;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp, rr;
	int failures = 0, num_checks = 0, cyc = 0;
	ptr_load_exec i_ptr_load_exec (.aclk, .aresetn, .op_valid, .op_code, .op_aux_sel,
		.op_short_imm, .op_long_imm, .op_indirect, .op_offset, .op_illegal, .dm_addr, .dm_region,
		.dm_rdata, .dm_we, .dm_waddr, .dm_wdata, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid,
		.s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
	dm_model #(.SALT(SALT)) i_dm_model (.aclk, .dm_addr, .dm_rdata, .dm_we, .dm_waddr, .dm_wdata,
		.wr_addr, .wr_data);
	always #12.5 aclk = ~aclk;
	task automatic results;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// a hang in any handshake ends up here
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			failures++;
			results();
		end
	end
	// op is launched here and taken at the next edge, inside the next op or idle
	task automatic op(input logic [3:0] c, input logic [2:0] s, input logic [8:0] i,
			input logic [15:0] l, input logic ind, input logic [6:0] o);
		@(posedge aclk);
		op_valid <= 1'b1;
		op_code <= c;
		op_aux_sel <= s;
		op_short_imm <= i;
		op_long_imm <= l;
		op_indirect <= ind;
		op_offset <= o;
		#1;
	endtask
	task automatic idle;
		@(posedge aclk);
		op_valid <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do @(posedge aclk); while (!s_arready);
		s_arvalid <= 1'b0;
		while (!s_rvalid) @(posedge aclk);
		rd = s_rdata;
		rr = s_rresp;
		s_rready <= 1'b0;
		chk(nm, rd, e);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= 4'hF;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (s_awvalid || s_wvalid);
		while (!s_bvalid) @(posedge aclk);
		rr = s_bresp;
		s_bready <= 1'b0;
	endtask
	task automatic t_page;
		op(OP_PAGE_IMM, 3'h0, 9'h1A5, 16'h0000, 1'b0, 7'h00);
		op(OP_AUX_LOAD, 3'h2, 9'h000, 16'h0000, 1'b0, 7'h11);
		chk("direct addr", dm_addr, {9'h1A5, 7'h11});
		op(OP_PAGE_LOAD, 3'h0, 9'h000, 16'h0000, 1'b0, 7'h22);
		idle();
		rchk(A_AUX_BASE + 8'h08, {9'h1A5, 7'h11} ^ SALT, "aux2");
		rchk(A_PAGE, 32'(({9'h1A5, 7'h22} ^ SALT) & 16'h01FF), "page mem");
	endtask
	task automatic t_aux;
		op(OP_AUX_SHORT, 3'h3, 9'h1F0, 16'h0000, 1'b0, 7'h00);
		op(OP_AUX_LONG, 3'h6, 9'h000, 16'hBEEF, 1'b0, 7'h00);
		op(OP_ARP_LOAD, 3'h0, 9'h1FE, 16'h0000, 1'b0, 7'h00);
		op(OP_PROD_HIGH, 3'h0, 9'h000, 16'h0000, 1'b1, 7'h00);
		chk("indirect addr", dm_addr, 16'hBEEF);
		op(OP_STAT_LOAD, 3'h0, 9'h000, 16'h0000, 1'b1, 7'h00);
		idle();
		rchk(A_AUX_BASE + 8'h0C, 32'h0000_00F0, "aux3 short");
		rchk(A_AUX_BASE + 8'h18, 32'h0000_BEEF, "aux6 long");
		rchk(A_ARP, 32'h0000_0006, "pointer");
		rchk(A_PROD, {16'hBEEF ^ SALT, 16'h0000}, "product");
		rchk(A_STAT0, 32'(16'hBEEF ^ SALT), "status0");
	endtask
	task automatic t_regions;
		logic [8:0] pg [8] = '{9'h008, 9'h005, 9'h006, 9'h000, 9'h000, 9'h004, 9'h007, 9'h003};
		logic [6:0] of [8] = '{7'h00, 7'h10, 7'h7F, 7'h60, 7'h5F, 7'h00, 7'h7F, 7'h60};
		logic [2:0] rg [8] = '{REG_EXTERNAL, REG_BLK_ZERO, REG_BLK_ONE, REG_BLK_TWO, REG_LOW,
			REG_BLK_ZERO, REG_BLK_ONE, REG_OTHER};
		for (int k = 0; k < 8; k++) begin
			op(OP_PAGE_IMM, 3'h0, pg[k], 16'h0000, 1'b0, 7'h00);
			op(OP_PROD_HIGH, 3'h0, 9'h000, 16'h0000, 1'b0, of[k]);
			chk("region", dm_region, rg[k]);
		end
	endtask
	task automatic t_copy_illegal;
		op(OP_PAGE_IMM, 3'h0, 9'h1FF, 16'h0000, 1'b0, 7'h00);
		op(OP_MAP_COPY, 3'h0, 9'h000, 16'h0321, 1'b0, 7'h45);
		chk("copy src", dm_addr, 16'h0045);
		op(4'hA, 3'h0, 9'h000, 16'h0000, 1'b0, 7'h00);
		chk("illegal", op_illegal, 1'b1);
		idle();
		chk("copy dst", wr_addr, 16'h0321);
		chk("copy data", wr_data, 16'h0045 ^ SALT);
		rchk(A_STATUS, 32'h0000_0001, "illegal count");
		wr_reg(A_STATUS, 32'h0000_0000);
		chk("status bresp", rr, RESP_OKAY);
		rchk(A_STATUS, 32'h0000_0000, "count cleared");
		rchk(8'h40, 32'h0000_0000, "unmapped rd");
		chk("unmapped rresp", rr, RESP_SLVERR);
		// halted: a page load must leave the page alone
		wr_reg(A_CTRL, 32'h0000_0001);
		chk("ctrl bresp", rr, RESP_OKAY);
		op(OP_PAGE_IMM, 3'h0, 9'h033, 16'h0000, 1'b0, 7'h00);
		idle();
		wr_reg(A_CTRL, 32'h0000_0000);
		rchk(A_PAGE, 32'h0000_01FF, "halted page");
		wr_reg(8'h44, 32'h0000_0001);
		chk("unmapped bresp", rr, RESP_SLVERR);
	endtask
	// a reset in mid-run must bring the registers back to zero
	task automatic t_reset;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(A_PAGE, 32'h0000_0000, "page after reset");
		rchk(A_AUX_BASE + 8'h18, 32'h0000_0000, "aux6 after reset");
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		rchk(A_PAGE, 32'h0000_0000, "page reset");
		t_page();
		t_aux();
		t_regions();
		t_copy_illegal();
		t_reset();
		results();
	end
endmodule
`default_nettype wire
